// file: verilog/beacon_adv_pkg.sv
// constants and types shared by the advertising scheduler
`default_nettype none
package beacon_adv_pkg;
	// -------------------------------------------------------------
	// register offsets
	// -------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_ADV_COUNT = 8'h08;
	localparam logic [7:0] ADDR_SLEEP_COUNT = 8'h0c;
	localparam logic [7:0] ADDR_FIELD_SRC_LO = 8'h10;
	localparam logic [7:0] ADDR_FIELD_SRC_HI = 8'h14;
	localparam logic [7:0] ADDR_FIELD_COUNT = 8'h18;
	localparam logic [7:0] ADDR_FETCH_ADDR = 8'h1c;
	// bank 0 is the stored (one-time) set, bank 1 the working-memory set
	localparam logic [1:0] BANK_STORED = 2'h1;
	localparam logic [1:0] BANK_WORKING = 2'h2;
	localparam logic [5:0] BOFF_INTERVAL = 6'h00;
	localparam logic [5:0] BOFF_BURST = 6'h04;
	localparam logic [5:0] BOFF_TRIG_MASK = 6'h08;
	localparam logic [5:0] BOFF_PREDEF = 6'h0c;
	localparam logic [5:0] BOFF_HEADER = 6'h10;
	localparam logic [5:0] BOFF_THR_BASE = 6'h14;
	// -------------------------------------------------------------
	// control bit positions
	// -------------------------------------------------------------
	localparam int CTRL_RUN = 0;
	localparam int CTRL_EVENT = 1;
	localparam int CTRL_SUBMODE_LSB = 2;
	localparam int CTRL_CFG_SRC = 4;
	localparam int CTRL_LOCK = 5;
	localparam int CTRL_WAKE_FALL = 6;
	localparam int CTRL_SENSOR0_LSB = 8;
	localparam int CTRL_SENSOR1_LSB = 10;
	localparam int CTRL_GPIO_LIVE = 12;
	localparam int CTRL_TIME_LSB = 13;
	// -------------------------------------------------------------
	// reset values and fixed counts
	// -------------------------------------------------------------
	localparam logic [31:0] INTERVAL_RST = 32'h0000_1000;
	localparam logic [15:0] BURST_RST = 16'h0005;
	localparam logic [3:0] FIELD_COUNT_RST = 4'h1;
	localparam logic [3:0] FIELD_MAX = 4'hf;
	localparam int NUM_THR = 7;
	localparam int ADC_W = 11;
	localparam logic [63:0] LFSR_RST = 64'h0123_4567_89ab_cdef;
	localparam int SEC_SHIFT = 15;
	typedef enum logic [3:0] {
		src_predef, src_timer, src_random, src_temp, src_supply, src_sensor0, src_sensor1,
		src_maker_uid, src_customer_uid, src_ephemeral, src_auth_tag, src_adv_count,
		src_sleep_count, src_gpio, src_pulse, src_register
	} src_type;
	typedef enum logic [2:0] {st_idle, st_wait, st_check, st_send, st_forever} state_type;
endpackage : beacon_adv_pkg
`default_nettype wire

// file: verilog/trigger_compare.sv
// one threshold comparison for a trigger condition
`timescale 1ns/1ns
`default_nettype none
module trigger_compare
	import beacon_adv_pkg::*;
#(
	parameter int WIDTH = ADC_W,
	parameter bit ABOVE = 1'b1
)
(
	input wire logic [WIDTH-1:0] level,
	input wire logic [WIDTH-1:0] threshold,
	output logic hit
);
	// -------------------------------------------------------------
	// compare
	// -------------------------------------------------------------
	generate
		if (WIDTH < 1)
		begin : g_bad
			$error("trigger_compare width must be positive");
		end
	endgenerate
	always_comb
	begin
		hit = ABOVE ? (level > threshold) : (level < threshold);
	end
endmodule : trigger_compare
`default_nettype wire

// file: verilog/field_source_mux.sv
// picks the data of one advertising field from its source
`timescale 1ns/1ns
`default_nettype none
module field_source_mux
	import beacon_adv_pkg::*;
(
	input wire src_type sel,
	input wire logic [1:0] time_sel,
	input wire logic [31:0] predef,
	input wire logic [31:0] always_on_timer,
	input wire logic [63:0] seconds_counter_value,
	input wire logic [63:0] random,
	input wire logic [10:0] temp,
	input wire logic [10:0] supply,
	input wire logic [10:0] sensor0,
	input wire logic [10:0] sensor1,
	input wire logic [31:0] maker_uid,
	input wire logic [31:0] customer_uid,
	input wire logic [31:0] ephemeral_identifier,
	input wire logic [31:0] auth_tag,
	input wire logic [31:0] advertising_event_count,
	input wire logic [31:0] sleep_count,
	input wire logic [7:0] gpio,
	input wire logic [31:0] pulse_count,
	input wire logic [31:0] fetch_data,
	output logic [31:0] data
);
	// -------------------------------------------------------------
	// time conversion and select
	// -------------------------------------------------------------
	logic [67:0] tenths_wide;
	always_comb
	begin
		// ticks * 10 / 32768: no divider, just a shift of the scaled count
		tenths_wide = {1'b0, seconds_counter_value, 3'h0} + {3'h0, seconds_counter_value, 1'b0};
		data = 32'h0000_0000;
		case (sel)
			src_predef: data = predef;
			src_timer:
			begin
				case (time_sel)
					2'h1: data = tenths_wide[SEC_SHIFT +: 32];
					2'h2: data = seconds_counter_value[SEC_SHIFT +: 32];
					default: data = always_on_timer;
				endcase
			end
			src_random: data = random[31:0];
			src_temp: data = {21'h0, temp};
			src_supply: data = {21'h0, supply};
			src_sensor0: data = {21'h0, sensor0};
			src_sensor1: data = {21'h0, sensor1};
			src_maker_uid: data = maker_uid;
			src_customer_uid: data = customer_uid;
			src_ephemeral: data = ephemeral_identifier;
			src_auth_tag: data = auth_tag;
			src_adv_count: data = advertising_event_count;
			src_sleep_count: data = sleep_count;
			src_gpio: data = {24'h0, gpio};
			src_pulse: data = pulse_count;
			src_register: data = fetch_data;
			default: data = 32'h0000_0000;
		endcase
	end
endmodule : field_source_mux
`default_nettype wire

// file: verilog/beacon_adv_control.sv
// advertising scheduler with trigger check and packet field sequencer
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - continuous mode sends one packet per interval
// - event mode sends only on configured triggers
// - four event sub-modes, numbered 0 to 3
// - sub-mode 0 bursts regardless of trigger persistence
// - sub-mode 0 sleeps forever after burst
// - sub-mode 1 rechecks trigger every advertising wake
// - sub-mode 1 restarts count; sleeps forever after
// - sub-mode 2 like 0, rechecks periodically after
// - sub-mode 3 like 1, rechecks periodically after
// - condition 0: supply below low-battery threshold
// - conditions 1,2: temperature above, below thresholds
// - conditions 3,4: selectable sensor 0 high/low
// - conditions 5,6: selectable sensor 1 high/low
// - condition 7: wake-up on the pin_wake input, selectable edge
// - packet holds at most fifteen ordered fields
// - field 0 header, others selectable source
// - predefined field from the selected stored or working configuration
// - timer field raw, tenths or whole seconds
// - sensor field from mixed-signal pins 4-7
// - random field from shift-register generator
// - identifiers, ephemeral id and auth tag selectable
// - advertising count and sleep count selectable
// - gpio state, pulse count, register value selectable
module beacon_adv_control
	import beacon_adv_pkg::*;
#(
	parameter int GPIO_W = 4
)
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [10:0] adc_supply,
	input wire logic [10:0] adc_temp,
	input wire logic [10:0] adc_mixed_signal_pin4,
	input wire logic [10:0] adc_mixed_signal_pin5,
	input wire logic [10:0] adc_mixed_signal_pin6,
	input wire logic [10:0] adc_mixed_signal_pin7,
	input wire logic pin_wake,
	input wire logic [GPIO_W-1:0] gpio_pins,
	input wire logic [31:0] always_on_timer,
	input wire logic [63:0] seconds_counter_value,
	input wire logic [31:0] maker_uid,
	input wire logic [31:0] customer_uid,
	input wire logic [31:0] ephemeral_identifier,
	input wire logic [31:0] auth_tag,
	input wire logic [31:0] pulse_count,
	input wire logic [31:0] fetch_data,
	output logic [31:0] fetch_addr,
	output logic tx_field_valid,
	input wire logic tx_field_ready,
	output logic [3:0] tx_field_index,
	output logic [31:0] tx_field_data,
	output logic tx_field_last,
	output logic adv_asleep
);
	generate
		if (GPIO_W < 1 || GPIO_W > 8)
		begin : g_bad
			$error("GPIO_W must lie in 1..8");
		end
	endgenerate
	// -------------------------------------------------------------
	// bus slave and registers
	// -------------------------------------------------------------
	logic wr_pend_q, wr_pend_d, rd_pend_q, rd_pend_d;
	logic [7:0] addr_q, addr_d;
	logic [31:0] hrdata_q, hrdata_d;
	logic hready_q, hready_d;
	logic [31:0] ctrl_q, ctrl_d, fetch_q, fetch_d;
	logic [63:0] fsrc_q, fsrc_d;
	logic [3:0] fcount_q, fcount_d;
	logic [31:0] interval_q [2], interval_d [2];
	logic [15:0] burst_q [2], burst_d [2];
	logic [7:0] mask_q [2], mask_d [2];
	logic [31:0] predef_q [2], predef_d [2];
	logic [31:0] header_q [2], header_d [2];
	logic [10:0] thr_q [2][NUM_THR], thr_d [2][NUM_THR];
	logic [31:0] adv_count_q, adv_count_d, sleep_count_q, sleep_count_d;
	logic [15:0] burst_left_q, burst_left_d;
	logic wake_flag_q, wake_flag_d;
	state_type state_q, state_d;
	logic [5:0] boff;
	logic bank_hit;
	logic bank;
	logic [2:0] thr_idx;
	logic addr_ok;
	logic sel_cfg;
	always_comb
	begin
		bank = (addr_q[7:6] == BANK_WORKING);
		bank_hit = (addr_q[7:6] == BANK_STORED) || (addr_q[7:6] == BANK_WORKING);
		boff = addr_q[5:0];
		thr_idx = 3'((boff - BOFF_THR_BASE) >> 2);
		sel_cfg = ctrl_q[CTRL_CFG_SRC];
		addr_ok = hsel && htrans[1] && hready;
		wr_pend_d = addr_ok && hwrite;
		rd_pend_d = addr_ok && !hwrite;
		addr_d = addr_ok ? haddr[7:0] : addr_q;
		// reads take one wait state so a read right after a write sees it
		hready_d = !rd_pend_d;
		hrdata_d = hrdata_q;
		ctrl_d = ctrl_q;
		fetch_d = fetch_q;
		fsrc_d = fsrc_q;
		fcount_d = fcount_q;
		interval_d = interval_q;
		burst_d = burst_q;
		mask_d = mask_q;
		predef_d = predef_q;
		header_d = header_q;
		thr_d = thr_q;
		if (wr_pend_q && !bank_hit)
		begin
			case (addr_q)
				// lock is sticky: once set only reset clears it
				ADDR_CTRL: ctrl_d = hwdata | (ctrl_q & (32'h1 << CTRL_LOCK));
				ADDR_FIELD_SRC_LO: fsrc_d[31:0] = hwdata;
				ADDR_FIELD_SRC_HI: fsrc_d[63:32] = {4'h0, hwdata[27:0]};
				ADDR_FIELD_COUNT: fcount_d = (hwdata[31:4] != 28'h0) ? FIELD_MAX : hwdata[3:0];
				ADDR_FETCH_ADDR: fetch_d = hwdata;
				default: ;
			endcase
		end
		// stored bank accepts writes only until locked
		if (wr_pend_q && bank_hit && (bank || !ctrl_q[CTRL_LOCK]))
		begin
			case (boff)
				BOFF_INTERVAL: interval_d[bank] = hwdata;
				BOFF_BURST: burst_d[bank] = hwdata[15:0];
				BOFF_TRIG_MASK: mask_d[bank] = hwdata[7:0];
				BOFF_PREDEF: predef_d[bank] = hwdata;
				BOFF_HEADER: header_d[bank] = hwdata;
				default:
				begin
					// bound on the full offset: a cut index would alias spare offsets onto thresholds
					if (boff >= BOFF_THR_BASE && boff - BOFF_THR_BASE < 6'(4 * NUM_THR) && boff[1:0] == 2'h0)
						thr_d[bank][thr_idx] = hwdata[10:0];
				end
			endcase
		end
		if (rd_pend_q)
		begin
			hrdata_d = 32'h0000_0000;
			if (bank_hit)
			begin
				case (boff)
					BOFF_INTERVAL: hrdata_d = interval_q[bank];
					BOFF_BURST: hrdata_d = {16'h0, burst_q[bank]};
					BOFF_TRIG_MASK: hrdata_d = {24'h0, mask_q[bank]};
					BOFF_PREDEF: hrdata_d = predef_q[bank];
					BOFF_HEADER: hrdata_d = header_q[bank];
					default:
					begin
						if (boff >= BOFF_THR_BASE && boff - BOFF_THR_BASE < 6'(4 * NUM_THR) && boff[1:0] == 2'h0)
							hrdata_d = {21'h0, thr_q[bank][thr_idx]};
					end
				endcase
			end
			else
			begin
				case (addr_q)
					ADDR_CTRL: hrdata_d = ctrl_q;
					ADDR_STATUS: hrdata_d = {burst_left_q, 11'h0, wake_flag_q, 1'b0, state_q};
					ADDR_ADV_COUNT: hrdata_d = adv_count_q;
					ADDR_SLEEP_COUNT: hrdata_d = sleep_count_q;
					ADDR_FIELD_SRC_LO: hrdata_d = fsrc_q[31:0];
					ADDR_FIELD_SRC_HI: hrdata_d = fsrc_q[63:32];
					ADDR_FIELD_COUNT: hrdata_d = {28'h0, fcount_q};
					ADDR_FETCH_ADDR: hrdata_d = fetch_q;
					default: hrdata_d = 32'h0000_0000;
				endcase
			end
		end
	end
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			addr_q <= 8'h00;
			hrdata_q <= 32'h0000_0000;
			hready_q <= 1'b1;
			ctrl_q <= 32'h0000_0000;
			fetch_q <= 32'h0000_0000;
			fsrc_q <= 64'h0000_0000_0000_0000;
			fcount_q <= FIELD_COUNT_RST;
			for (int b = 0; b < 2; b++)
			begin
				interval_q[b] <= INTERVAL_RST;
				burst_q[b] <= BURST_RST;
				mask_q[b] <= 8'h00;
				predef_q[b] <= 32'h0000_0000;
				header_q[b] <= 32'h0000_0000;
				for (int t = 0; t < NUM_THR; t++)
					thr_q[b][t] <= 11'h000;
			end
		end
		else
		begin
			wr_pend_q <= wr_pend_d;
			rd_pend_q <= rd_pend_d;
			addr_q <= addr_d;
			hrdata_q <= hrdata_d;
			hready_q <= hready_d;
			ctrl_q <= ctrl_d;
			fetch_q <= fetch_d;
			fsrc_q <= fsrc_d;
			fcount_q <= fcount_d;
			interval_q <= interval_d;
			burst_q <= burst_d;
			mask_q <= mask_d;
			predef_q <= predef_d;
			header_q <= header_d;
			thr_q <= thr_d;
		end
	end
	assign hrdata = hrdata_q;
	assign hreadyout = hready_q;
	assign hresp = 1'b0;
	assign fetch_addr = fetch_q;
	// -------------------------------------------------------------
	// pin synchronisers and trigger conditions
	// -------------------------------------------------------------
	logic [GPIO_W:0] sync1_q, sync2_q, sync3_q;
	logic [7:0] wake_gpio_q, wake_gpio_d;
	logic [10:0] sensor0, sensor1;
	logic [10:0] cmp_level [NUM_THR];
	logic [7:0] cond;
	logic [NUM_THR-1:0] thr_hit;
	logic wake_edge, trig;
	always_comb
	begin
		// sensor 0 pin chosen from mixed-signal pins 4-7
		case (ctrl_q[CTRL_SENSOR0_LSB +: 2])
			2'h1: sensor0 = adc_mixed_signal_pin5;
			2'h2: sensor0 = adc_mixed_signal_pin6;
			2'h3: sensor0 = adc_mixed_signal_pin7;
			default: sensor0 = adc_mixed_signal_pin4;
		endcase
		// sensor 1 has its own pin choice
		case (ctrl_q[CTRL_SENSOR1_LSB +: 2])
			2'h1: sensor1 = adc_mixed_signal_pin5;
			2'h2: sensor1 = adc_mixed_signal_pin6;
			2'h3: sensor1 = adc_mixed_signal_pin7;
			default: sensor1 = adc_mixed_signal_pin4;
		endcase
		cmp_level[0] = adc_supply;
		// temperature against high and low thresholds
		cmp_level[1] = adc_temp;
		cmp_level[2] = adc_temp;
		cmp_level[3] = sensor0;
		cmp_level[4] = sensor0;
		cmp_level[5] = sensor1;
		cmp_level[6] = sensor1;
		// pin wake edge, polarity chosen by control
		wake_edge = ctrl_q[CTRL_WAKE_FALL] ? (sync3_q[GPIO_W] && !sync2_q[GPIO_W])
			: (!sync3_q[GPIO_W] && sync2_q[GPIO_W]);
		cond = {wake_flag_q, thr_hit};
		// only enabled conditions of the selected set count
		trig = |(cond & mask_q[sel_cfg]);
		wake_gpio_d = wake_edge ? 8'(sync2_q[GPIO_W-1:0]) : wake_gpio_q;
	end
	genvar gi;
	generate
		for (gi = 0; gi < NUM_THR; gi++)
		begin : g_cmp
			trigger_compare #(
				.WIDTH(ADC_W),
				.ABOVE(gi % 2 == 1)
			) u_cmp (
				.level(cmp_level[gi]),
				.threshold(thr_q[sel_cfg][gi]),
				.hit(thr_hit[gi])
			);
		end
	endgenerate
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			sync1_q <= '0;
			sync2_q <= '0;
			sync3_q <= '0;
			wake_gpio_q <= 8'h00;
		end
		else
		begin
			sync1_q <= {pin_wake, gpio_pins};
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			wake_gpio_q <= wake_gpio_d;
		end
	end
	// -------------------------------------------------------------
	// advertising sequencer
	// -------------------------------------------------------------
	logic [31:0] wait_cnt_q, wait_cnt_d;
	logic [63:0] lfsr_q, lfsr_d, lfsr_step;
	logic [3:0] next_idx;
	logic [31:0] mux_data;
	logic tx_valid_q, tx_valid_d, tx_last_q, tx_last_d, asleep_q, asleep_d;
	logic [3:0] tx_index_q, tx_index_d;
	logic [31:0] tx_data_q, tx_data_d;
	logic [15:0] burst_cfg, burst_next;
	logic load_field;
	always_comb
	begin
		burst_cfg = (burst_q[sel_cfg] == 16'h0) ? 16'h1 : burst_q[sel_cfg];
		state_d = state_q;
		wait_cnt_d = wait_cnt_q;
		adv_count_d = adv_count_q;
		sleep_count_d = sleep_count_q;
		burst_left_d = burst_left_q;
		burst_next = burst_left_q;
		// a new wake edge in the clearing cycle still stands
		wake_flag_d = wake_edge || (wake_flag_q && state_q != st_check);
		tx_valid_d = tx_valid_q;
		tx_index_d = tx_index_q;
		tx_data_d = tx_data_q;
		tx_last_d = tx_last_q;
		load_field = 1'b0;
		next_idx = tx_valid_q ? tx_index_q + 4'h1 : 4'h0;
		// generator free-runs; seeded from converter bits while idle
		lfsr_step = {lfsr_q[62:0], lfsr_q[63] ^ lfsr_q[62] ^ lfsr_q[60] ^ lfsr_q[59]};
		lfsr_d = lfsr_step;
		case (state_q)
			st_idle:
			begin
				lfsr_d = lfsr_step ^ {60'h0, adc_supply[0], adc_temp[0], adc_mixed_signal_pin4[0],
					adc_mixed_signal_pin5[0]};
				if (lfsr_d == 64'h0)
					lfsr_d = LFSR_RST;
				wait_cnt_d = 32'h0;
				burst_left_d = 16'h0;
				if (ctrl_q[CTRL_RUN])
					state_d = st_wait;
			end
			st_wait:
			begin
				if (wait_cnt_q + 32'h1 >= interval_q[sel_cfg])
				begin
					wait_cnt_d = 32'h0;
					sleep_count_d = sleep_count_q + 32'h1;
					state_d = ctrl_q[CTRL_EVENT] ? st_check : st_send;
				end
				else
					wait_cnt_d = wait_cnt_q + 32'h1;
			end
			st_check:
			begin
				// sub-mode bit 0 rechecks in burst, bit 1 rechecks after
				if (burst_left_q == 16'h0)
				begin
					// a new trigger after the burst starts another
					if (trig)
					begin
						burst_left_d = burst_cfg;
						state_d = st_send;
					end
					else
						state_d = st_wait;
				end
				else
				begin
					// sub-modes 1 and 3 restart the count on trigger
					if (ctrl_q[CTRL_SUBMODE_LSB] && trig)
						burst_left_d = burst_cfg;
					// sub-modes 0 and 2 keep sending regardless
					state_d = st_send;
				end
			end
			st_send:
			begin
				if (!tx_valid_q || tx_field_ready)
				begin
					if (tx_valid_q && tx_last_q)
					begin
						tx_valid_d = 1'b0;
						adv_count_d = adv_count_q + 32'h1;
						burst_next = burst_left_q - 16'h1;
						if (ctrl_q[CTRL_EVENT])
							burst_left_d = burst_next;
						// sub-modes 0 and 1 sleep for good after the burst
						if (ctrl_q[CTRL_EVENT] && burst_next == 16'h0 && !ctrl_q[CTRL_SUBMODE_LSB + 1])
							state_d = st_forever;
						else
							state_d = st_wait;
					end
					else
						load_field = 1'b1;
				end
			end
			st_forever: ;
			default: state_d = st_idle;
		endcase
		if (load_field)
		begin
			// fields go out in order, last one flagged
			tx_valid_d = 1'b1;
			tx_index_d = next_idx;
			tx_last_d = (next_idx + 4'h1 >= fcount_q);
			// field 0 is the header, others from their source
			tx_data_d = (next_idx == 4'h0) ? header_q[sel_cfg] : mux_data;
		end
		if (!ctrl_q[CTRL_RUN])
		begin
			state_d = st_idle;
			tx_valid_d = 1'b0;
		end
		asleep_d = (state_d == st_wait) || (state_d == st_forever);
	end
	field_source_mux u_mux (
		.sel(src_type'(fsrc_q[{next_idx, 2'h0} +: 4])),
		.time_sel(ctrl_q[CTRL_TIME_LSB +: 2]),
		.predef(predef_q[sel_cfg]),
		.always_on_timer(always_on_timer),
		.seconds_counter_value(seconds_counter_value),
		.random(lfsr_q),
		.temp(adc_temp),
		.supply(adc_supply),
		.sensor0(sensor0),
		.sensor1(sensor1),
		.maker_uid(maker_uid),
		.customer_uid(customer_uid),
		.ephemeral_identifier(ephemeral_identifier),
		.auth_tag(auth_tag),
		.advertising_event_count(adv_count_q),
		.sleep_count(sleep_count_q),
		.gpio(ctrl_q[CTRL_GPIO_LIVE] ? 8'(sync2_q[GPIO_W-1:0]) : wake_gpio_q),
		.pulse_count(pulse_count),
		.fetch_data(fetch_data),
		.data(mux_data)
	);
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			state_q <= st_idle;
			wait_cnt_q <= 32'h0;
			adv_count_q <= 32'h0;
			sleep_count_q <= 32'h0;
			burst_left_q <= 16'h0;
			wake_flag_q <= 1'b0;
			lfsr_q <= LFSR_RST;
			tx_valid_q <= 1'b0;
			tx_index_q <= 4'h0;
			tx_data_q <= 32'h0;
			tx_last_q <= 1'b0;
			asleep_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			wait_cnt_q <= wait_cnt_d;
			adv_count_q <= adv_count_d;
			sleep_count_q <= sleep_count_d;
			burst_left_q <= burst_left_d;
			wake_flag_q <= wake_flag_d;
			lfsr_q <= lfsr_d;
			tx_valid_q <= tx_valid_d;
			tx_index_q <= tx_index_d;
			tx_data_q <= tx_data_d;
			tx_last_q <= tx_last_d;
			asleep_q <= asleep_d;
		end
	end
	assign tx_field_valid = tx_valid_q;
	assign tx_field_index = tx_index_q;
	assign tx_field_data = tx_data_q;
	assign tx_field_last = tx_last_q;
	assign adv_asleep = asleep_q;
endmodule : beacon_adv_control
`default_nettype wire

// file: bench/radio_sink.sv
// radio side model that takes advertising fields
`timescale 1ns/1ns
`default_nettype none
module radio_sink
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic slow,
	input wire logic valid,
	input wire logic [3:0] index,
	input wire logic [31:0] data,
	input wire logic last,
	output logic ready,
	output var int pkts,
	output logic [31:0] fld [3]
);
	// slow mode stalls every other cycle to exercise holding
	always_ff @(posedge mclk)
	begin
		ready <= rst_n && (!slow || !ready);
		if (!rst_n)
			pkts <= 0;
		else if (valid && ready)
		begin
			fld[index[1:0]] <= data;
			pkts <= pkts + (last ? 1 : 0);
		end
	end
endmodule : radio_sink
`default_nettype wire

// file: bench/beacon_adv_chk.sv
// assertions on the scheduler ports
`timescale 1ns/1ns
`default_nettype none
module beacon_adv_chk
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic tx_field_valid,
	input wire logic tx_field_ready,
	input wire logic [3:0] tx_field_index,
	input wire logic [31:0] tx_field_data,
	input wire logic tx_field_last,
	input wire logic adv_asleep
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	sequence s_stall;
		tx_field_valid && !tx_field_ready;
	endsequence
	sequence s_take;
		tx_field_valid && tx_field_ready;
	endsequence
	a_field_hold: assert property (s_stall ##1 tx_field_valid
		|-> $stable(tx_field_index) && $stable(tx_field_data)) else $error("field changed while stalled");
	a_index_max: assert property (tx_field_valid |-> tx_field_index <= 4'he)
		else $error("field index too high");
	a_index_step: assert property (s_take ##0 !tx_field_last ##1 tx_field_valid
		|-> tx_field_index == $past(tx_field_index) + 4'h1) else $error("field index skipped");
	a_header_first: assert property ($rose(tx_field_valid) |-> tx_field_index == 4'h0)
		else $error("packet not opened by header");
	a_last_ends: assert property (s_take ##0 tx_field_last |=> !tx_field_valid)
		else $error("stream went on after last field");
	a_sleep_quiet: assert property (adv_asleep |-> !tx_field_valid)
		else $error("field offered while asleep");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("bus response not okay");
	a_read_wait: assert property (hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
endmodule : beacon_adv_chk
bind beacon_adv_control beacon_adv_chk u_chk (.mclk, .rst_n, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp,
	.tx_field_valid, .tx_field_ready, .tx_field_index, .tx_field_data, .tx_field_last, .adv_asleep);
`default_nettype wire

// file: bench/test_beacon_adv_control.sv
// self-checking bench for the advertising scheduler
`timescale 1ns/1ns
`default_nettype none
module test_beacon_adv_control
	import beacon_adv_pkg::*;
;
	logic mclk = 1'b0, rst_n = 1'b0, hwrite = 1'b0, slow = 1'b0, wake = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, tick = 32'h0, hrdata, rdata, tx_data, faddr;
	logic [1:0] htrans = 2'h0;
	logic [10:0] supply = 11'h7ff;
	logic hreadyout, hresp, tx_valid, tx_ready, tx_last, asleep;
	logic [3:0] tx_index;
	logic [31:0] fld [3];
	int pkts, n, fails = 0, cmp_count = 0;
	initial forever #4 mclk = ~mclk;
	always @(posedge mclk) tick <= tick + 32'h1;
	beacon_adv_control dut (.mclk, .rst_n, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .adc_supply(supply), .adc_temp(tick[10:0]),
		.adc_mixed_signal_pin4(tick[11:1]), .adc_mixed_signal_pin5(tick[12:2]), .adc_mixed_signal_pin6(tick[13:3]),
		.adc_mixed_signal_pin7(tick[14:4]), .pin_wake(wake), .gpio_pins(tick[3:0]), .always_on_timer(tick),
		.seconds_counter_value({tick, tick}), .maker_uid(32'h5a5a_0001), .customer_uid(~tick),
		.ephemeral_identifier(tick), .auth_tag(~tick), .pulse_count(tick), .fetch_data(tick), .fetch_addr(faddr),
		.tx_field_valid(tx_valid), .tx_field_ready(tx_ready), .tx_field_index(tx_index),
		.tx_field_data(tx_data), .tx_field_last(tx_last), .adv_asleep(asleep));
	radio_sink radio (.mclk, .rst_n, .slow, .valid(tx_valid), .index(tx_index), .data(tx_data),
		.last(tx_last), .ready(tx_ready), .pkts, .fld);
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		rdata = hrdata;
	endtask : xfer
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			fails++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		xfer(a, 1'b0, 32'h0);
		chk(rdata, e);
	endtask : rc
	task automatic results;
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : results
	// the whole run needs well under 10000 cycles
	initial
	begin
		#400000;
		fails++;
		results;
	end
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial
	begin
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		rc(ADDR_FIELD_COUNT, 32'h1);
		rc({BANK_WORKING, BOFF_BURST}, 32'h5);
		rc({BANK_WORKING, BOFF_INTERVAL}, 32'h1000);
		rc(8'h30, 32'h0);
		xfer(ADDR_FIELD_COUNT, 1'b1, 32'h1f);
		rc(ADDR_FIELD_COUNT, 32'hf);
		xfer({BANK_STORED, BOFF_PREDEF}, 1'b1, 32'h1234);
		xfer(ADDR_CTRL, 1'b1, 32'h20);
		xfer({BANK_STORED, BOFF_PREDEF}, 1'b1, 32'h5678);
		rc({BANK_STORED, BOFF_PREDEF}, 32'h1234);
		xfer(ADDR_FETCH_ADDR, 1'b1, 32'h0000_0abc);
		rc(ADDR_FETCH_ADDR, 32'h0000_0abc);
		chk(faddr, 32'h0000_0abc);
		$display("test registers done");
		xfer({BANK_WORKING, BOFF_INTERVAL}, 1'b1, 32'h14);
		xfer({BANK_WORKING, BOFF_HEADER}, 1'b1, 32'hc0de_0001);
		xfer(ADDR_FIELD_COUNT, 1'b1, 32'h3);
		xfer(ADDR_FIELD_SRC_LO, 1'b1, {20'h0, src_maker_uid, src_adv_count, 4'h0});
		slow <= 1'b1;
		xfer(ADDR_CTRL, 1'b1, 32'h11);
		n = 0;
		while (pkts < 2 && n < 500)
		begin
			@(posedge mclk);
			n++;
		end
		xfer(ADDR_CTRL, 1'b1, 32'h0);
		chk(fld[0], 32'hc0de_0001);
		chk(fld[1], 32'h1);
		chk(fld[2], 32'h5a5a_0001);
		rc(ADDR_ADV_COUNT, 32'(pkts));
		$display("test continuous done");
		slow <= 1'b0;
		xfer({BANK_WORKING, BOFF_BURST}, 1'b1, 32'h2);
		xfer({BANK_WORKING, BOFF_TRIG_MASK}, 1'b1, 32'h1);
		xfer({BANK_WORKING, BOFF_THR_BASE}, 1'b1, 32'h100);
		xfer(ADDR_FIELD_COUNT, 1'b1, 32'h1);
		for (int m = 0; m < 4; m++)
		begin
			n = pkts;
			supply <= 11'h010;
			xfer(ADDR_CTRL, 1'b1, 32'h13 | (m << 2));
			repeat (150) @(posedge mclk);
			supply <= 11'h7ff;
			repeat (200) @(posedge mclk);
			// only sub-mode 0 ignores a lasting trigger
			chk(32'(pkts - n > 2), 32'(m > 0));
			if (m == 0)
				chk(32'(pkts - n), 32'h2);
			xfer(ADDR_STATUS, 1'b0, 32'h0);
			chk(32'(rdata[2:0] == 3'h4), 32'(m < 2));
			n = pkts;
			supply <= 11'h010;
			repeat (150) @(posedge mclk);
			supply <= 11'h7ff;
			chk(32'(pkts > n), 32'(m > 1));
			xfer(ADDR_CTRL, 1'b1, 32'h0);
			$display("test sub-mode %0d done", m);
		end
		xfer({BANK_WORKING, BOFF_TRIG_MASK}, 1'b1, 32'h80);
		n = pkts;
		xfer(ADDR_CTRL, 1'b1, 32'h13);
		repeat (30) @(posedge mclk);
		chk(32'(pkts - n), 32'h0);
		wake <= 1'b1;
		repeat (150) @(posedge mclk);
		chk(32'(pkts - n), 32'h2);
		chk({31'h0, asleep}, 32'h1);
		$display("test pin wake done");
		results;
	end
endmodule : test_beacon_adv_control
`default_nettype wire
